// *** bench/apt_assertions.sv ***
`include "apt_cfg.svh"
module apt_assertions (
  input wire logic                   clk,
  input wire logic                   reset_n,
  input wire logic [`APT_REG_AW-1:0] regAddr,
  input wire logic                   regWr,
  input wire logic                   regRd,
  input wire logic [15:0]            regRdData,
  input wire logic                   convBusy,
  input wire logic                   convDone,
  input wire logic                   convStart,
  input wire logic                   convPair,
  input wire logic                   irq
);
  logic inFlight;
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);
  sequence statusRead;
    regRd && regAddr == 2'h1 && !convDone;
  endsequence
  sequence holeRead;
    regRd && regAddr == 2'h3;
  endsequence
  // done in the start cycle itself belongs to that start
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) inFlight <= 1'b0;
    else if (convStart || convDone) inFlight <= convStart && !convDone;
  end
  a_start_pulse: assert property (convStart |=> !convStart)
    else $error("start pulse longer than one cycle");
  a_no_start_busy: assert property (convBusy |=> !convStart)
    else $error("start issued while converter busy");
  a_start_once: assert property (convStart |-> !inFlight)
    else $error("start issued before previous done");
  a_pair_stable: assert property (!convStart |-> $stable(convPair))
    else $error("pair select moved without a start");
  a_read_idle: assert property (!regRd |=> regRdData == 16'h0000)
    else $error("read data not zero outside read slot");
  a_read_hole: assert property (holeRead |=> regRdData == 16'h0000)
    else $error("unmapped read returned data");
  a_irq_cause: assert property ($rose(irq) |-> $past(convDone)
    || $past(regWr && regAddr == 2'h2)) else $error("irq rose without cause");
  a_irq_clear_read: assert property (statusRead |=> !irq)
    else $error("irq still high after status read");
endmodule
bind apt_pair_trigger_control apt_assertions chkInst (.clk(clk), .reset_n(reset_n),
  .regAddr(regAddr), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
  .convBusy(convBusy), .convDone(convDone), .convStart(convStart),
  .convPair(convPair), .irq(irq));

// *** bench/apt_conv_model.sv ***
module apt_conv_model (
  input  wire logic       clk,
  input  wire logic       reset_n,
  input  wire logic       convStart,
  input  wire logic       busyReq,
  input  wire logic [3:0] lag,
  output logic            convBusy,
  output logic            convDone
);
  logic [3:0] cnt;
  // busy stands for conversions of other pairs, steered by the bench
  assign convBusy = busyReq;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      cnt <= 4'h0;
      convDone <= 1'b0;
    end else begin
      convDone <= (cnt == 4'h1);
      if (convStart) cnt <= lag;
      else if (cnt != 4'h0) cnt <= cnt - 4'h1;
    end
  end
endmodule

// *** bench/tb_top.sv ***
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, reset_n, regWr, regRd, busyReq, rdLast;
  logic        convBusy, convDone, convStart, convPair, irq;
  logic [1:0]  regAddr;
  logic [15:0] regWrData, regRdData, trigVec;
  logic [3:0]  lag;
  logic [31:0] seed;
  logic [15:0] expQ[$];
  int          numErrors, testsRun, cycles, startCnt, n0;
  apt_pair_trigger_control uut (.clk(clk), .reset_n(reset_n), .clkEn(1'b1),
    .regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd),
    .regRdData(regRdData), .timer1Match(trigVec[14]), .timer2Match(trigVec[15]),
    .pwmPrimaryTrig(trigVec[5:2]), .pwmSecondaryTrig(trigVec[9:6]),
    .pwmLimitTrig(trigVec[13:10]), .pwmSpecialTrig(trigVec[1]),
    .globalSoftTrig(trigVec[0]), .convBusy(convBusy), .convDone(convDone),
    .convStart(convStart), .convPair(convPair), .irq(irq));
  apt_conv_model partner (.clk(clk), .reset_n(reset_n), .convStart(convStart),
    .busyReq(busyReq), .lag(lag), .convBusy(convBusy), .convDone(convDone));
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    s ^= s << 5;
    return s;
  endfunction
  // one trigger line per source code; zero for the individual soft-bit code 01 and dead codes, global soft line for code 02
  function automatic logic [15:0] sel(input logic [4:0] c);
    case (c) inside
      5'h02, 5'h03: sel = 16'h0001 << (c - 5'h02);
      [5'h04:5'h07]: sel = 16'h0004 << (c - 5'h04);
      [5'h0E:5'h11]: sel = 16'h0040 << (c - 5'h0E);
      [5'h17:5'h1A]: sel = 16'h0400 << (c - 5'h17);
      5'h0C: sel = 16'h4000;
      5'h1F: sel = 16'h8000;
      default: sel = 16'h0000;
    endcase
  endfunction
  task automatic wrapUp();
    if (numErrors == 0 && testsRun > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input logic [15:0] e, input logic [15:0] g);
    testsRun++;
    if (g !== e) begin
      numErrors++;
      $display("FAIL t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask
  task automatic wr(input logic [1:0] a, input logic [15:0] d);
    @(posedge clk);
    regWr <= 1'b1;
    regAddr <= a;
    regWrData <= d;
    @(posedge clk);
    regWr <= 1'b0;
  endtask
  task automatic rd(input logic [1:0] a, input logic [15:0] e);
    expQ.push_back(e);
    @(posedge clk);
    regRd <= 1'b1;
    regAddr <= a;
    @(posedge clk);
    regRd <= 1'b0;
  endtask
  task automatic pulse(input logic [15:0] t);
    @(posedge clk);
    trigVec <= t;
    @(posedge clk);
    trigVec <= 16'h0000;
  endtask
  task automatic waitFor(input bit d);
    int n;
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while ((d ? convDone : convStart) !== 1'b1 && n < 60);
    // a missed pulse must not slip through as a silent wait
    if (n >= 60) begin
      numErrors++;
      $display("FAIL t=%0t exp=%h got=%h", $time, 1'b1, 1'b0);
    end
  endtask
  task automatic runPair(input int p, input logic [4:0] c);
    logic [15:0] v;
    v = (16'h0080 | c) << (8 * p);
    wr(2'h0, v);
    if (c == 5'h01 || (p == 1 && c == 5'h02)) wr(2'h0, v | (16'h0020 << (8 * p)));
    else pulse(sel(c));
    waitFor(0);
    chk(16'(p), {15'h0, convPair});
    rd(2'h0, v | (16'h0040 << (8 * p)));
    waitFor(1);
    @(negedge clk);
    chk(16'h0001, {15'h0, irq});
    rd(2'h1, 16'h0001 << p);
    rd(2'h0, v);
  endtask
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (convStart === 1'b1) startCnt++;
    if (rdLast) chk(expQ.pop_front(), regRdData);
    rdLast <= regRd;
    if (cycles == 20000) begin
      numErrors++;
      wrapUp();
    end
  end
  initial begin
    {reset_n, regWr, regRd, busyReq, rdLast, regAddr, regWrData, trigVec} = '0;
    lag = 4'h4;
    seed = 32'h6f42;
    repeat (2) @(posedge clk);
    reset_n <= 1'b1;
    rd(2'h0, 16'h0000);
    rd(2'h3, 16'h0000);
    wr(2'h2, 16'h0003);
    for (int c = 0; c < 32; c++) begin
      seed = xs(seed);
      lag <= 4'h4 + {1'b0, seed[2:0]};
      if (sel(5'(c)) != 0 || c == 1) runPair(int'(seed[3]), 5'(c));
      else begin
        // soft bits armed under a dead code must not start anything
        wr(2'h0, {3'b001, 5'(c), 3'b001, 5'(c)});
        pulse(16'hFFFF);
        rd(2'h0, {3'b001, 5'(c), 3'b001, 5'(c)});
      end
    end
    wr(2'h2, 16'h0002);
    @(posedge clk);
    busyReq <= 1'b1;
    wr(2'h0, 16'h8C8C);
    pulse(16'h4000);
    n0 = startCnt;
    repeat (6) @(negedge clk);
    chk(16'(n0), 16'(startCnt));
    @(posedge clk);
    busyReq <= 1'b0;
    waitFor(0);
    chk(16'h0000, {15'h0, convPair});
    waitFor(1);
    @(negedge clk);
    chk(16'h0000, {15'h0, irq});
    waitFor(0);
    chk(16'h0001, {15'h0, convPair});
    waitFor(1);
    @(negedge clk);
    chk(16'h0001, {15'h0, irq});
    rd(2'h1, 16'h0003);
    rd(2'h0, 16'h8C8C);
    // let the monitor take the last read before closing
    repeat (2) @(posedge clk);
    wrapUp();
  end
endmodule

// *** common/apt_cfg.svh ***
`ifndef APT_CFG_SVH
`define APT_CFG_SVH

`define APT_NUM_PAIRS    2
`define APT_REG_AW       2
`define APT_REG_CTRL     2'h0
`define APT_REG_STATUS   2'h1
`define APT_REG_MASK     2'h2
`define APT_CTRL_RESET   16'h0000
`define APT_PAIR_STRIDE  8
`define APT_SRC_LSB      0
`define APT_SRC_W        5
`define APT_SOFT_BIT     5
`define APT_PEND_BIT     6
`define APT_IRQEN_BIT    7

`define APT_SRC_TMR2     5'h1F
`define APT_SRC_LIM4     5'h1A
`define APT_SRC_LIM3     5'h19
`define APT_SRC_LIM2     5'h18
`define APT_SRC_LIM1     5'h17
`define APT_SRC_SEC4     5'h11
`define APT_SRC_SEC3     5'h10
`define APT_SRC_SEC2     5'h0F
`define APT_SRC_SEC1     5'h0E
`define APT_SRC_TMR1     5'h0C
`define APT_SRC_PRI4     5'h07
`define APT_SRC_PRI3     5'h06
`define APT_SRC_PRI2     5'h05
`define APT_SRC_PRI1     5'h04
`define APT_SRC_SPECIAL  5'h03
`define APT_SRC_GLOBSW   5'h02
`define APT_SRC_INDSW    5'h01
`define APT_SRC_OFF      5'h00
`endif

// *** common/apt_pkg.sv ***
package apt_pkg;
  typedef logic [4:0] apt_src_t;
  typedef enum logic [1:0] {
    APT_IDLE = 2'b00,
    APT_BUSY = 2'b01
  } apt_state_t;
endpackage

// *** verilog/apt_pair_trigger_control.sv ***
`include "apt_cfg.svh"
module apt_pair_trigger_control (
  input  wire logic                   clk,
  input  wire logic                   reset_n,
  input  wire logic                   clkEn,
  input  wire logic [`APT_REG_AW-1:0] regAddr,
  input  wire logic [15:0]            regWrData,
  input  wire logic                   regWr,
  input  wire logic                   regRd,
  output logic      [15:0]            regRdData,
  input  wire logic                   timer1Match,
  input  wire logic                   timer2Match,
  input  wire logic [3:0]             pwmPrimaryTrig,
  input  wire logic [3:0]             pwmSecondaryTrig,
  input  wire logic [3:0]             pwmLimitTrig,
  input  wire logic                   pwmSpecialTrig,
  input  wire logic                   globalSoftTrig,
  input  wire logic                   convBusy,
  input  wire logic                   convDone,
  output logic                        convStart,
  output logic                        convPair,
  output logic                        irq
);
  import apt_pkg::*;

  localparam int NP = `APT_NUM_PAIRS;

  logic [15:0]   ctrlView;
  logic [15:0]   regRdData_reg;
  logic [NP-1:0] pending_reg;
  logic [NP-1:0] queued_reg;
  logic [NP-1:0] softBit_reg;
  logic [NP-1:0] irqEn_reg;
  logic [NP-1:0] trigHit;
  logic [NP-1:0] startGrant;
  logic [NP-1:0] doneHit;
  logic [NP-1:0] status_reg;
  logic [NP-1:0] status_next;
  logic [NP-1:0] mask_reg;
  apt_src_t      srcSel_reg [NP];
  apt_state_t    state_reg;
  logic          convStart_reg;
  logic          convPair_reg;
  logic          ctrlWr;
  logic          maskWr;
  logic          statusRd;

  assign ctrlWr   = regWr && (regAddr == `APT_REG_CTRL);
  assign maskWr   = regWr && (regAddr == `APT_REG_MASK);
  assign statusRd = regRd && (regAddr == `APT_REG_STATUS);

  // index 0 is pair 4 (channels 9/8), index 1 is pair 5 (channels 11/10)
  for (genvar p = 0; p < NP; p++) begin : g_pair
    localparam int B = p * `APT_PAIR_STRIDE;

    apt_trigger_select u_sel (
      .srcSel           (srcSel_reg[p]),
      .softTrig         (softBit_reg[p]),
      .globalSoftTrig   (globalSoftTrig),
      .timer1Match      (timer1Match),
      .timer2Match      (timer2Match),
      .pwmPrimaryTrig   (pwmPrimaryTrig),
      .pwmSecondaryTrig (pwmSecondaryTrig),
      .pwmLimitTrig     (pwmLimitTrig),
      .pwmSpecialTrig   (pwmSpecialTrig),
      .hit              (trigHit[p])
    );

    assign doneHit[p] = (state_reg == APT_BUSY) && convDone && (convPair_reg == 1'(p));

    assign ctrlView[B +: `APT_PAIR_STRIDE] = {irqEn_reg[p], pending_reg[p], softBit_reg[p],
                                              srcSel_reg[p]};

    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        srcSel_reg[p] <= `APT_SRC_OFF;
        irqEn_reg[p]  <= 1'b0;
      end else if (clkEn && ctrlWr) begin
        srcSel_reg[p] <= regWrData[B + `APT_SRC_LSB +: `APT_SRC_W];
        irqEn_reg[p]  <= regWrData[B + `APT_IRQEN_BIT];
      end
    end

    // the bit only acts under a soft source code; otherwise it waits until a ctrl write or a hit of the selected source clears it
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        softBit_reg[p] <= 1'b0;
      end else if (clkEn) begin
        if (trigHit[p]) begin
          softBit_reg[p] <= 1'b0;
        end else if (ctrlWr) begin
          softBit_reg[p] <= regWrData[B + `APT_SOFT_BIT];
        end
      end
    end

    // queued means not yet handed to the converter; a retrigger while in flight requeues
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        queued_reg[p] <= 1'b0;
      end else if (clkEn) begin
        if (trigHit[p]) begin
          queued_reg[p] <= 1'b1;
        end else if (startGrant[p]) begin
          queued_reg[p] <= 1'b0;
        end
      end
    end

    // pending is read-only to software; a new trigger outweighs a completion
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        pending_reg[p] <= 1'b0;
      end else if (clkEn) begin
        if (trigHit[p]) begin
          pending_reg[p] <= 1'b1;
        end else if (doneHit[p] && !queued_reg[p]) begin
          pending_reg[p] <= 1'b0;
        end
      end
    end
  end

  // fixed priority: pair 4 first; pair 5 can starve only under back-to-back pair-4 triggers
  always_comb begin
    startGrant = '0;
    if ((state_reg == APT_IDLE) && !convBusy) begin
      if (queued_reg[0]) begin
        startGrant[0] = 1'b1;
      end else if (queued_reg[1]) begin
        startGrant[1] = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_reg     <= APT_IDLE;
      convStart_reg <= 1'b0;
      convPair_reg  <= 1'b0;
    end else if (clkEn) begin
      case (state_reg)
        APT_IDLE: begin
          convStart_reg <= 1'b0;
          if (|startGrant) begin
            convStart_reg <= 1'b1;
            convPair_reg  <= startGrant[1];
            state_reg     <= APT_BUSY;
          end
        end
        APT_BUSY: begin
          convStart_reg <= 1'b0;
          if (convDone) begin
            state_reg <= APT_IDLE;
          end
        end
        default: begin
          convStart_reg <= 1'b0;
          state_reg     <= APT_IDLE;
        end
      endcase
    end
  end

  // completion sets wins over the clear-on-read of the same cycle
  assign status_next = (statusRd ? '0 : status_reg) | (doneHit & irqEn_reg);

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      status_reg <= '0;
    end else if (clkEn) begin
      status_reg <= status_next;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      mask_reg <= '0;
    end else if (clkEn && maskWr) begin
      mask_reg <= regWrData[NP-1:0];
    end
  end

  // read data stand for the single cycle after the strobe, zero otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      regRdData_reg <= `APT_CTRL_RESET;
    end else if (clkEn) begin
      regRdData_reg <= 16'h0000;
      if (regRd) begin
        case (regAddr)
          `APT_REG_CTRL:   regRdData_reg <= ctrlView;
          `APT_REG_STATUS: regRdData_reg <= {{(16-NP){1'b0}}, status_reg};
          `APT_REG_MASK:   regRdData_reg <= {{(16-NP){1'b0}}, mask_reg};
          default:         regRdData_reg <= 16'h0000;
        endcase
      end
    end
  end

  assign regRdData = regRdData_reg;
  assign convStart = convStart_reg;
  assign convPair  = convPair_reg;
  assign irq       = |(status_reg & mask_reg);
endmodule

// *** verilog/apt_trigger_select.sv ***
`include "apt_cfg.svh"
module apt_trigger_select (
  input  apt_pkg::apt_src_t srcSel,
  input  wire logic         softTrig,
  input  wire logic         globalSoftTrig,
  input  wire logic         timer1Match,
  input  wire logic         timer2Match,
  input  wire logic [3:0]   pwmPrimaryTrig,
  input  wire logic [3:0]   pwmSecondaryTrig,
  input  wire logic [3:0]   pwmLimitTrig,
  input  wire logic         pwmSpecialTrig,
  output logic              hit
);
  import apt_pkg::*;

  always_comb begin
    case (srcSel)
      `APT_SRC_TMR2:    hit = timer2Match;
      `APT_SRC_TMR1:    hit = timer1Match;
      `APT_SRC_LIM4:    hit = pwmLimitTrig[3];
      `APT_SRC_LIM3:    hit = pwmLimitTrig[2];
      `APT_SRC_LIM2:    hit = pwmLimitTrig[1];
      `APT_SRC_LIM1:    hit = pwmLimitTrig[0];
      `APT_SRC_SEC4:    hit = pwmSecondaryTrig[3];
      `APT_SRC_SEC3:    hit = pwmSecondaryTrig[2];
      `APT_SRC_SEC2:    hit = pwmSecondaryTrig[1];
      `APT_SRC_SEC1:    hit = pwmSecondaryTrig[0];
      `APT_SRC_PRI4:    hit = pwmPrimaryTrig[3];
      `APT_SRC_PRI3:    hit = pwmPrimaryTrig[2];
      `APT_SRC_PRI2:    hit = pwmPrimaryTrig[1];
      `APT_SRC_PRI1:    hit = pwmPrimaryTrig[0];
      `APT_SRC_SPECIAL: hit = pwmSpecialTrig;
      `APT_SRC_GLOBSW:  hit = softTrig | globalSoftTrig;
      `APT_SRC_INDSW:   hit = softTrig;
      `APT_SRC_OFF:     hit = 1'b0;
      default:          hit = 1'b0;
    endcase
  end
endmodule
